// [logic/supply_drop_detect_control.sv]
// Register access over AHB-Lite and the register offsets were decided locally.
`timescale 1ns/100ps
module supply_drop_detect_control (
  // clock and system reset
  input  wire logic        mclk_i,
  input  wire logic        rst_b_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // comparator side
  input  wire logic        below_threshold_i,
  output logic             comparator_enable_o,
  output logic [supply_drop_pkg::LEVEL_W-1:0] threshold_select_o,
  // processor low-power state, same clock domain
  input  wire logic        low_power_active_i,
  // events to core interrupt and reset logic
  output logic             low_supply_irq_o,
  output logic             vd_reset_o
);

  import supply_drop_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic addr_hit(input logic [31:0] addr, input logic [15:0] base);
    addr_hit = (addr[31:16] == 16'h0000) && (addr[15:0] == base);
  endfunction : addr_hit

  function automatic logic valid_level(input logic [LEVEL_W-1:0] code);
    valid_level = (code == LEVEL_VALID);
  endfunction : valid_level

  ////////////////////////////////////////////////////////////////////////////
  // comparator synchroniser

  logic below_sync;

  level_sync u_below_sync (
    .mclk_i  (mclk_i),
    .rst_b_i (rst_b_i),
    .async_i (below_threshold_i),
    .sync_o  (below_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus address phase capture

  logic        wr_one_q;
  logic        wr_one_d;
  logic        wr_two_q;
  logic        wr_two_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        addr_valid;
  logic        hit_one;
  logic        hit_two;

  always_comb begin
    addr_valid = hsel_i && hready_i && (htrans_i == HTRANS_NONSEQ);
    hit_one    = addr_hit(haddr_i, CTRL_ONE_ADDR);
    hit_two    = addr_hit(haddr_i, CTRL_TWO_ADDR);
    wr_one_d   = addr_valid && hwrite_i && hit_one;
    wr_two_d   = addr_valid && hwrite_i && hit_two;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      wr_one_q  <= 1'b0;
      wr_two_q  <= 1'b0;
    end else begin
      wr_one_q  <= wr_one_d;
      wr_two_q  <= wr_two_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detect_control_two: action select, enable, spare bits

  logic                  enable_q;
  logic                  enable_d;
  logic                  action_q;
  logic                  action_d;
  logic [C2_SPARE_W-1:0] spare2_q;
  logic [C2_SPARE_W-1:0] spare2_d;

  always_comb begin
    enable_d = enable_q;
    action_d = action_q;
    spare2_d = spare2_q;
    if (wr_two_q) begin
      enable_d = hwdata_i[C2_ENABLE_POS];
      action_d = hwdata_i[C2_ACTION_POS];
      spare2_d = hwdata_i[C2_SPARE_LSB +: C2_SPARE_W];
    end
  end

  // only system reset lands here; own vd reset never does
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      enable_q <= CTRL_TWO_RESET[C2_ENABLE_POS];
      action_q <= CTRL_TWO_RESET[C2_ACTION_POS];
      spare2_q <= CTRL_TWO_RESET[C2_SPARE_LSB +: C2_SPARE_W];
    end else begin
      enable_q <= enable_d;
      action_q <= action_d;
      spare2_q <= spare2_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detect_control_one: level select and spare bits

  logic [LEVEL_W-1:0] level_q;
  logic [LEVEL_W-1:0] level_d;
  logic               spare7_q;
  logic               spare7_d;
  logic               spare5_q;
  logic               spare5_d;
  logic               spare4_q;
  logic               spare4_d;

  always_comb begin
    level_d  = level_q;
    spare7_d = spare7_q;
    spare5_d = spare5_q;
    spare4_d = spare4_q;
    if (wr_one_q) begin
      // reserved codes are refused, field keeps its value
      if (valid_level(hwdata_i[C1_LEVEL_LSB +: LEVEL_W])) begin
        level_d = hwdata_i[C1_LEVEL_LSB +: LEVEL_W];
      end
      spare7_d = hwdata_i[C1_SPARE7_POS];
      spare5_d = hwdata_i[C1_SPARE5_POS];
      spare4_d = hwdata_i[C1_SPARE4_POS];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      level_q  <= CTRL_ONE_RESET[C1_LEVEL_LSB +: LEVEL_W];
      spare7_q <= CTRL_ONE_RESET[C1_SPARE7_POS];
      spare5_q <= CTRL_ONE_RESET[C1_SPARE5_POS];
      spare4_q <= CTRL_ONE_RESET[C1_SPARE4_POS];
    end else begin
      level_q  <= level_d;
      spare7_q <= spare7_d;
      spare5_q <= spare5_d;
      spare4_q <= spare4_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags

  logic sticky_q;
  logic sticky_d;
  logic live_q;
  logic live_d;
  logic detect_low;
  logic sticky_clr;
  logic running;
  logic [SYNC_STAGES-1:0] en_hist_q;
  logic [SYNC_STAGES-1:0] en_hist_d;

  always_comb begin
    running    = !low_power_active_i;
    // synchroniser still holds samples taken while comparator was off
    en_hist_d  = {en_hist_q[SYNC_STAGES-2:0], enable_q};
    detect_low = enable_q && (&en_hist_q) && below_sync;
    // writing one to the sticky bit is ignored
    sticky_clr = wr_one_q && !hwdata_i[C1_STICKY_POS];
    sticky_d   = sticky_q;
    live_d     = live_q;
    if (sticky_clr) begin
      sticky_d = 1'b0;
    end
    if (running) begin
      // both flags follow the same synchronised sample
      live_d = detect_low;
      if (detect_low) begin
        sticky_d = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      sticky_q  <= CTRL_ONE_RESET[C1_STICKY_POS];
      live_q    <= CTRL_ONE_RESET[C1_LIVE_POS];
      en_hist_q <= '0;
    end else begin
      sticky_q  <= sticky_d;
      live_q    <= live_d;
      en_hist_q <= en_hist_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event generation

  logic seen_low_q;
  logic seen_low_d;
  logic irq_q;
  logic irq_d;
  logic vd_reset_q;
  logic vd_reset_d;

  always_comb begin
    seen_low_d = seen_low_q;
    irq_d      = 1'b0;
    // frozen in low power, so a crossing there fires on exit
    if (running) begin
      seen_low_d = detect_low;
      // new low, or enable set while already low
      if (detect_low && !seen_low_q && (action_q == ACTION_IRQ)) begin
        irq_d = 1'b1;
      end
    end
    // reset level follows comparator, no hold of its own
    vd_reset_d = detect_low && (action_q == ACTION_RESET);
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      seen_low_q <= 1'b0;
      irq_q      <= 1'b0;
      vd_reset_q <= 1'b0;
    end else begin
      seen_low_q <= seen_low_d;
      irq_q      <= irq_d;
      vd_reset_q <= vd_reset_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data, captured in the address phase

  logic [7:0] ctrl_one_view;
  logic [7:0] ctrl_two_view;

  always_comb begin
    ctrl_one_view                             = 8'h00;
    ctrl_one_view[C1_SPARE7_POS]              = spare7_q;
    ctrl_one_view[C1_SPARE5_POS]              = spare5_q;
    ctrl_one_view[C1_SPARE4_POS]              = spare4_q;
    ctrl_one_view[C1_STICKY_POS]              = sticky_q;
    ctrl_one_view[C1_LIVE_POS]                = live_q;
    ctrl_one_view[C1_LEVEL_LSB +: LEVEL_W]    = level_q;
    ctrl_two_view                             = 8'h00;
    ctrl_two_view[C2_SPARE_LSB +: C2_SPARE_W] = spare2_q;
    ctrl_two_view[C2_ACTION_POS]              = action_q;
    ctrl_two_view[C2_ENABLE_POS]              = enable_q;
    rdata_d = 32'h0000_0000;
    if (addr_valid && !hwrite_i && hit_one) begin
      rdata_d = {24'h00_0000, ctrl_one_view};
    end else if (addr_valid && !hwrite_i && hit_two) begin
      rdata_d = {24'h00_0000, ctrl_two_view};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // comparator control outputs

  logic               comp_en_q;
  logic               comp_en_d;
  logic [LEVEL_W-1:0] level_out_q;
  logic [LEVEL_W-1:0] level_out_d;

  always_comb begin
    comp_en_d   = enable_d;
    level_out_d = level_d;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      comp_en_q   <= 1'b0;
      level_out_q <= LEVEL_VALID;
    end else begin
      comp_en_q   <= comp_en_d;
      level_out_q <= level_out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero-wait slave, always OKAY; ready and resp are constant flops
  logic ready_q;
  logic resp_q;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      ready_q <= 1'b1;
      resp_q  <= HRESP_OKAY;
    end else begin
      ready_q <= 1'b1;
      resp_q  <= HRESP_OKAY;
    end
  end

  assign hrdata_o            = rdata_q;
  assign hreadyout_o         = ready_q;
  assign hresp_o             = resp_q;
  assign comparator_enable_o = comp_en_q;
  assign threshold_select_o  = level_out_q;
  assign low_supply_irq_o    = irq_q;
  assign vd_reset_o          = vd_reset_q;

endmodule : supply_drop_detect_control

// [common/supply_drop_pkg.sv]
package supply_drop_pkg;

  // register indexes as printed; byte address is four times the index
  localparam logic [15:0] CTRL_ONE_INDEX  = 16'h0fc6;
  localparam logic [15:0] CTRL_TWO_INDEX  = 16'h0fc7;
  localparam logic [15:0] CTRL_ONE_ADDR   = {CTRL_ONE_INDEX[13:0], 2'b00};
  localparam logic [15:0] CTRL_TWO_ADDR   = {CTRL_TWO_INDEX[13:0], 2'b00};

  // detect_control_one field positions
  localparam int unsigned C1_SPARE7_POS   = 7;
  localparam int unsigned C1_SPARE5_POS   = 5;
  localparam int unsigned C1_SPARE4_POS   = 4;
  localparam int unsigned C1_STICKY_POS   = 3;
  localparam int unsigned C1_LIVE_POS     = 2;
  localparam int unsigned C1_LEVEL_LSB    = 0;
  localparam int unsigned LEVEL_W         = 2;

  // detect_control_two field positions
  localparam int unsigned C2_SPARE_LSB    = 2;
  localparam int unsigned C2_SPARE_W      = 4;
  localparam int unsigned C2_ACTION_POS   = 1;
  localparam int unsigned C2_ENABLE_POS   = 0;

  // values after power-on or external reset
  localparam logic [7:0]  CTRL_ONE_RESET  = 8'h20;
  localparam logic [7:0]  CTRL_TWO_RESET  = 8'h00;
  localparam logic [1:0]  LEVEL_VALID     = 2'h0;

  // action select encodings
  localparam logic        ACTION_IRQ      = 1'b0;
  localparam logic        ACTION_RESET    = 1'b1;

  // ahb-lite transfer types and responses
  localparam logic [1:0]  HTRANS_IDLE     = 2'h0;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic        HRESP_OKAY      = 1'b0;

  // synchroniser depth on the comparator path
  localparam int unsigned SYNC_STAGES     = 2;

  // skew allowance between live and sticky flags, unused; both flags update in the same clock cycle
  localparam int unsigned FLAG_SKEW_CYC   = 2;

endpackage : supply_drop_pkg

// [logic/level_sync.sv]
`timescale 1ns/100ps
module level_sync (
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic rst_b_i,
  // asynchronous level in, synchronised level out
  input  wire logic async_i,
  output logic      sync_o
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // first stage feeds only the second stage
  always_comb begin
    meta_d = async_i;
    sync_d = meta_q;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_o = sync_q;

endmodule : level_sync

// [sim/supply_drop_checker.sv]
`timescale 1ns/100ps
module supply_drop_checker (
  // clock and reset
  input wire logic                                 mclk_i,
  input wire logic                                 rst_b_i,
  // comparator side
  input wire logic                                 below_threshold_i,
  input wire logic                                 low_power_active_i,
  input wire logic                                 comparator_enable_o,
  input wire logic [supply_drop_pkg::LEVEL_W-1:0] threshold_select_o,
  // events
  input wire logic                                 low_supply_irq_o,
  input wire logic                                 vd_reset_o
);
  import supply_drop_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  a_idle_no_event: assert property (
    !comparator_enable_o && !$past(comparator_enable_o) |-> !low_supply_irq_o && !vd_reset_o)
    else $error("event while detection off");
  a_enable_cleared: assert property ($rose(rst_b_i) |-> !comparator_enable_o)
    else $error("enable set after reset");
  a_one_event_kind: assert property (!(low_supply_irq_o && vd_reset_o))
    else $error("irq and reset together");
  a_irq_pulse: assert property (low_supply_irq_o |=> !low_supply_irq_o)
    else $error("irq longer than one cycle");
  a_irq_frozen: assert property (low_supply_irq_o |-> !$past(low_power_active_i))
    else $error("irq during low power");
  a_event_sync_cause: assert property (
    low_supply_irq_o || vd_reset_o |-> $past(below_threshold_i, 3))
    else $error("event without synchronised low");
  a_reset_holds: assert property (
    vd_reset_o && $past(below_threshold_i, 2) |=> vd_reset_o || !comparator_enable_o)
    else $error("reset dropped while low");
  a_level_valid: assert property (threshold_select_o == LEVEL_VALID)
    else $error("reserved level reached comparator");
endmodule : supply_drop_checker

bind supply_drop_detect_control supply_drop_checker supply_drop_checker_inst (
  .mclk_i              (mclk_i),
  .rst_b_i             (rst_b_i),
  .below_threshold_i   (below_threshold_i),
  .low_power_active_i  (low_power_active_i),
  .comparator_enable_o (comparator_enable_o),
  .threshold_select_o  (threshold_select_o),
  .low_supply_irq_o    (low_supply_irq_o),
  .vd_reset_o          (vd_reset_o)
);

// [sim/supply_comparator_model.sv]
`timescale 1ns/100ps
module supply_comparator_model (
  // clock and commanded supply state
  input  wire logic                                 mclk_i,
  input  wire logic                                 supply_low_i,
  // control from the block
  input  wire logic                                 comparator_enable_i,
  input  wire logic [supply_drop_pkg::LEVEL_W-1:0] threshold_select_i,
  // comparator result, asynchronous
  output logic                                      below_threshold_o
);
  import supply_drop_pkg::*;
  logic low_q;
  logic junk_q;
  initial begin
    low_q = 1'b0;
    junk_q = 1'b0;
  end
  // analog delay keeps edges off the clock
  always @(supply_low_i) low_q <= #7 supply_low_i;
  // unpowered comparator output means nothing
  always @(posedge mclk_i) junk_q <= ~junk_q;
  assign below_threshold_o = (comparator_enable_i && threshold_select_i == LEVEL_VALID) ?
                             low_q : junk_q;
endmodule : supply_comparator_model

// [sim/supply_drop_detect_control_tb.sv]
`timescale 1ns/100ps
module supply_drop_detect_control_tb;
  import supply_drop_pkg::*;
  logic        mclk_i;
  logic        rst_b_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        below;
  logic        cmp_en;
  logic [1:0]  thr;
  logic        lp_i;
  logic        irq;
  logic        vdr;
  logic        supply_low;
  int spare1, en, act, sticky, live, low, lp, exp_irq, irq_seen, error_cnt, n_compared, d;

  supply_drop_detect_control supply_drop_detect_control_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp), .below_threshold_i(below),
    .comparator_enable_o(cmp_en), .threshold_select_o(thr), .low_power_active_i(lp_i),
    .low_supply_irq_o(irq), .vd_reset_o(vdr));
  supply_comparator_model supply_comparator_model_inst (
    .mclk_i(mclk_i), .supply_low_i(supply_low), .comparator_enable_i(cmp_en),
    .threshold_select_i(thr), .below_threshold_o(below));

  initial begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) if (irq === 1'b1) irq_seen++;

  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] dw,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge mclk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= HTRANS_IDLE;
    hwdata <= dw;
    do @(posedge mclk_i); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [15:0] a, input int v);
    logic [31:0] r;
    bus(1'b1, a, 32'(v), r);
  endtask : wr
  task automatic rdc(input logic [15:0] a, input int e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, 32'(e));
    chk({31'h0, hresp}, 32'(HRESP_OKAY));
  endtask : rdc
  task automatic look;
    rdc(CTRL_ONE_ADDR, spare1 | sticky << 3 | live << 2);
    chk(32'(irq_seen), 32'(exp_irq));
    chk({31'h0, vdr}, 32'(en && act && low));
    chk({31'h0, cmp_en}, 32'(en));
    chk({30'h0, thr}, 32'(LEVEL_VALID));
  endtask : look
  task automatic supply(input int v);
    if (v && !low && en && !lp && !act) exp_irq++;
    low = v;
    supply_low <= v[0];
    repeat (6) @(posedge mclk_i);
    if (en && !lp) live = low;
    if (en && !lp && low) sticky = 1;
  endtask : supply

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge mclk_i);
    error_cnt++;
    final_report();
  end
  initial begin
    {rst_b_i, hsel, haddr, htrans, hwrite, hwdata, lp_i, supply_low} = '0;
    {en, act, sticky, live, low, lp, exp_irq, irq_seen, error_cnt, n_compared} = '0;
    spare1 = 32'h20;
    void'($urandom(32'h9626));
    repeat (8) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    rdc(CTRL_ONE_ADDR, CTRL_ONE_RESET);
    rdc(CTRL_TWO_ADDR, CTRL_TWO_RESET);
    rdc(16'h0000, 0);
    d = $urandom() & 32'hb0;
    wr(CTRL_ONE_ADDR, d | 32'h8);
    spare1 = d;
    rdc(CTRL_ONE_ADDR, spare1);
    for (int lv = 1; lv < 4; lv++) begin
      wr(CTRL_ONE_ADDR, spare1 | lv);
      rdc(CTRL_ONE_ADDR, spare1);
    end
    supply(1);
    look();
    wr(CTRL_TWO_ADDR, 1);
    en = 1;
    exp_irq++;
    supply(1);
    look();
    supply(0);
    look();
    supply(1);
    supply(0);
    look();
    wr(CTRL_TWO_ADDR, 0);
    en = 0;
    look();
    wr(CTRL_ONE_ADDR, spare1);
    sticky = 0;
    look();
    wr(CTRL_TWO_ADDR, 1);
    en = 1;
    lp_i <= 1'b1;
    lp = 1;
    supply(1);
    look();
    lp_i <= 1'b0;
    lp = 0;
    exp_irq++;
    supply(1);
    look();
    supply(0);
    wr(CTRL_ONE_ADDR, spare1);
    sticky = 0;
    wr(CTRL_TWO_ADDR, 3);
    act = 1;
    supply(1);
    look();
    wr(CTRL_ONE_ADDR, spare1);
    look();
    supply(0);
    supply(1);
    look();
    rdc(CTRL_TWO_ADDR, 3);
    supply(0);
    wr(CTRL_TWO_ADDR, 1);
    act = 0;
    wr(CTRL_TWO_ADDR, 0);
    en = 0;
    look();
    final_report();
  end
endmodule : supply_drop_detect_control_tb
